/* nvts_defines.svh */
// What this block does
// - Hardware reset starts automatic trim read without host command or supply, when idle with display off.
// - Software reset command does not start the automatic read.
// - Successful auto read steps status pair 00, 10, 11, 01.
// - Status pair 01 means trim read done, display may be enabled.
// - High voltage uses program level for program/erase, read level for read.
// - Status read returns write_success, mtp_variant_flag, mtp_sequence_active live.
// - Cells are read back after program or erase to verify.
// - Verified program or erase ends with write_success set.
// - Failed verify retries twice more; after three fails clear write_success, abort.
// - mtp_variant_flag is a fixed constant and never changes.
// - Store holds eight cell bits; 5:0 trim, 7:6 maker configuration.
// - Contrast equals potentiometer minus magnitude if bit5 set, else plus.
// - NV operations and display-on are exclusive; violating command ignored, except display-on in the cycle a hardware reset starts auto read.
`ifndef NVTS_DEFINES_SVH
`define NVTS_DEFINES_SVH
`define NVTS_CMD_READ_LEVEL 8'hf4
`define NVTS_CMD_PROG_LEVEL 8'hf5
`define NVTS_CMD_WR_TIMER 8'hf6
`define NVTS_CMD_RD_TIMER 8'hf7
`define NVTS_CMD_MASK 8'hb9
`define NVTS_CMD_CONTROL 8'hb8
`define NVTS_CMD_SYS_RESET 8'he2
`define NVTS_CMD_DISP_EN_HI 7'h57
`define NVTS_OP_ERASE 3'h2
`define NVTS_OP_PROGRAM 3'h3
`define NVTS_CTRL_GO_BIT 3
`define NVTS_RST_READ_LEVEL 8'h00
`define NVTS_RST_PROG_LEVEL 8'h39
`define NVTS_RST_WR_TIMER 8'h27
`define NVTS_RST_RD_TIMER 8'h04
`define NVTS_MAX_TRIES 2'h3
`define NVTS_TICK_US 250
`define NVTS_STAT_OK_BIT 2
`define NVTS_STAT_VARIANT_BIT 1
`define NVTS_STAT_ACTIVE_BIT 0
`endif

/* nvts_pkg.sv */
package nvts_pkg;
    typedef enum logic [5:0] {
        NVTS_IDLE = 6'b000001,
        NVTS_RD_SETUP = 6'b000010,
        NVTS_READ = 6'b000100,
        NVTS_RD_DONE = 6'b001000,
        NVTS_WRITE = 6'b010000,
        NVTS_VERIFY = 6'b100000
    } nvts_state_t;
    typedef struct packed {
        logic write_success;
        logic mtp_variant_flag;
        logic mtp_sequence_active;
    } nvts_status_t;
    typedef struct packed {
        logic [7:0] read_level_setting;
        logic [7:0] program_level_setting;
    } nvts_levels_t;
endpackage : nvts_pkg

/* nvts_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nvts_defines.svh"
module nvts_sequencer #(
    parameter logic MTP_VARIANT = 1'b0, // Arbitrary variant value
    parameter int TICK_CYCLES = 250 * `NVTS_TICK_US
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hw_reset_event,
    // Host command port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Nonvolatile array
    input wire logic [7:0] cell_in,
    output logic [7:0] cell_out,
    output logic cell_read_en,
    output logic cell_write_en,
    output logic cell_erase,
    output nvts_pkg::nvts_levels_t levels,
    output logic [7:0] hv_level,
    // Trim and display
    input wire logic [7:0] contrast_potentiometer,
    output logic [7:0] contrast_trimmed,
    output logic [7:0] trim_offset,
    output logic display_on
);
    // ------------------------------------------------
    // Command decode
    // ------------------------------------------------
    nvts_pkg::nvts_state_t state, next_state;
    nvts_pkg::nvts_status_t status;
    logic [7:0] cell_bit_mask, write_timer_setting, read_timer_setting;
    logic [7:0] pend_cmd;
    logic pend;
    logic [7:0] cells;
    logic [2:0] nv_operation_control;
    logic [1:0] tries;
    logic [19:0] tick_cnt;
    logic [7:0] tmr;
    logic hw_s1, hw_s2, hw_s3;
    logic [7:0] rdata_next;
    wire op_erase = nv_operation_control == `NVTS_OP_ERASE;
    wire busy = (state != nvts_pkg::NVTS_IDLE);
    wire cmd_wr = wr && addr[0] == 1'b0;
    wire data_phase = cmd_wr && pend;
    wire is_disp = cmd_wr && !pend && wdata[7:1] == `NVTS_CMD_DISP_EN_HI;
    wire is_two = wdata == `NVTS_CMD_READ_LEVEL || wdata == `NVTS_CMD_PROG_LEVEL
        || wdata == `NVTS_CMD_WR_TIMER || wdata == `NVTS_CMD_RD_TIMER
        || wdata == `NVTS_CMD_MASK || wdata == `NVTS_CMD_CONTROL;
    wire ctrl_go = data_phase && pend_cmd == `NVTS_CMD_CONTROL && wdata[`NVTS_CTRL_GO_BIT]
        && (wdata[2:0] == `NVTS_OP_ERASE || wdata[2:0] == `NVTS_OP_PROGRAM);
    wire hw_rise = hw_s2 && !hw_s3;
    wire start_op = ctrl_go && !busy && !display_on && !hw_rise;
    wire tick = tick_cnt == 20'(TICK_CYCLES - 1);
    wire tmr_done = tick && tmr <= 8'h01;
    assign rdata_next = {5'h00, status.write_success, status.mtp_variant_flag,
        status.mtp_sequence_active};
    assign hv_level = (state == nvts_pkg::NVTS_WRITE) ? levels.program_level_setting
        : levels.read_level_setting;
    assign cell_read_en = state == nvts_pkg::NVTS_READ || state == nvts_pkg::NVTS_VERIFY;
    assign cell_write_en = state == nvts_pkg::NVTS_WRITE && !op_erase;
    assign cell_erase = state == nvts_pkg::NVTS_WRITE && op_erase;
    assign trim_offset = {2'h0, cells[5:0]};
    assign cell_out = op_erase ? (cells & ~cell_bit_mask) : (cells | cell_bit_mask);
    // ------------------------------------------------
    // Host register writes
    // ------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
            pend_cmd <= 8'h00;
            cell_bit_mask <= 8'h00;
            write_timer_setting <= `NVTS_RST_WR_TIMER;
            read_timer_setting <= `NVTS_RST_RD_TIMER;
            levels <= {`NVTS_RST_READ_LEVEL, `NVTS_RST_PROG_LEVEL};
            display_on <= 1'b0;
            nv_operation_control <= 3'h0;
            rdata <= 8'h00;
        end else begin
            rdata <= rd ? rdata_next : 8'h00;
            if (cmd_wr) begin
                pend <= !pend && is_two;
                pend_cmd <= wdata;
            end
            if (is_disp && !(busy && wdata[0])) begin
                display_on <= wdata[0];
            end
            if (cmd_wr && !pend && wdata == `NVTS_CMD_SYS_RESET) begin
                display_on <= 1'b0;
            end
            if (data_phase && !busy) begin
                if (pend_cmd == `NVTS_CMD_WR_TIMER) write_timer_setting <= wdata;
                if (pend_cmd == `NVTS_CMD_RD_TIMER) read_timer_setting <= wdata;
                if (pend_cmd == `NVTS_CMD_READ_LEVEL) levels.read_level_setting <= wdata;
                if (pend_cmd == `NVTS_CMD_PROG_LEVEL) levels.program_level_setting <= wdata;
                if (pend_cmd == `NVTS_CMD_MASK) cell_bit_mask <= wdata;
            end
            if (start_op) nv_operation_control <= wdata[2:0];
        end
    end
    // ------------------------------------------------
    // Sequencer
    // ------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            // auto read, not on software reset
            nvts_pkg::NVTS_IDLE: begin
                if (hw_rise && !display_on) next_state = nvts_pkg::NVTS_RD_SETUP;
                else if (start_op) next_state = nvts_pkg::NVTS_WRITE;
            end
            nvts_pkg::NVTS_RD_SETUP: if (tmr_done) next_state = nvts_pkg::NVTS_READ;
            nvts_pkg::NVTS_READ: if (tmr_done) next_state = nvts_pkg::NVTS_RD_DONE;
            nvts_pkg::NVTS_RD_DONE: if (tmr_done) next_state = nvts_pkg::NVTS_IDLE;
            nvts_pkg::NVTS_WRITE: if (tmr_done) next_state = nvts_pkg::NVTS_VERIFY;
            nvts_pkg::NVTS_VERIFY: begin
                if (tmr_done) begin
                    if (cell_in == cell_out || tries == `NVTS_MAX_TRIES)
                        next_state = nvts_pkg::NVTS_IDLE;
                    else next_state = nvts_pkg::NVTS_WRITE;
                end
            end
        endcase
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= nvts_pkg::NVTS_IDLE;
            hw_s1 <= 1'b0;
            hw_s2 <= 1'b0;
            hw_s3 <= 1'b0;
            tick_cnt <= 20'h00000;
            tmr <= 8'h00;
            tries <= 2'h0;
            cells <= 8'h00;
            status.mtp_variant_flag <= MTP_VARIANT;
            status.write_success <= 1'b0;
            status.mtp_sequence_active <= 1'b0;
        end else begin
            hw_s1 <= hw_reset_event;
            hw_s2 <= hw_s1;
            hw_s3 <= hw_s2;
            state <= next_state;
            tick_cnt <= (tick || next_state != state) ? 20'h00000 : tick_cnt + 20'h00001;
            if (next_state != state) begin
                tmr <= (next_state == nvts_pkg::NVTS_WRITE) ? write_timer_setting
                    : read_timer_setting;
            end else if (tick && tmr != 8'h00) begin
                tmr <= tmr - 8'h01;
            end
            if (state == nvts_pkg::NVTS_IDLE && next_state == nvts_pkg::NVTS_RD_SETUP) begin
                status.write_success <= 1'b0;
                status.mtp_sequence_active <= 1'b0;
            end
            if (state == nvts_pkg::NVTS_RD_SETUP && next_state == nvts_pkg::NVTS_READ)
                status.mtp_sequence_active <= 1'b1;
            if (state == nvts_pkg::NVTS_READ && next_state == nvts_pkg::NVTS_RD_DONE) begin
                cells <= cell_in;
                status.write_success <= 1'b1;
            end
            if (state == nvts_pkg::NVTS_RD_DONE && next_state == nvts_pkg::NVTS_IDLE)
                status.mtp_sequence_active <= 1'b0;
            if (start_op) begin
                tries <= 2'h1;
                status.mtp_sequence_active <= 1'b1;
                status.write_success <= 1'b0;
            end
            if (state == nvts_pkg::NVTS_VERIFY && next_state == nvts_pkg::NVTS_WRITE)
                tries <= tries + 2'h1;
            if (state == nvts_pkg::NVTS_VERIFY && next_state == nvts_pkg::NVTS_IDLE) begin
                status.mtp_sequence_active <= 1'b0;
                status.write_success <= cell_in == cell_out;
                if (cell_in == cell_out) cells <= cell_in;
            end
        end
    end
    wire [8:0] sum = {1'b0, contrast_potentiometer} + {4'h0, cells[4:0]};
    wire [8:0] dif = {1'b0, contrast_potentiometer} - {4'h0, cells[4:0]};
    always_ff @(posedge clk) begin
        if (!rst_n) contrast_trimmed <= 8'h00;
        else if (cells[5]) contrast_trimmed <= dif[8] ? 8'h00 : dif[7:0];
        else contrast_trimmed <= sum[8] ? 8'hff : sum[7:0];
    end
    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    // variant constant
    a_variant_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        status.mtp_variant_flag == MTP_VARIANT) else $error("variant changed");
    a_excl_disp: assert property (@(posedge clk) disable iff (!rst_n)
        (ctrl_go && display_on && state == nvts_pkg::NVTS_IDLE) |=> state == nvts_pkg::NVTS_IDLE)
        else $error("op started while display on");
    a_disp_busy: assert property (@(posedge clk) disable iff (!rst_n)
        (busy && !display_on) |=> !display_on)
        else $error("display enabled during operation");
    a_write_verify: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_WRITE && next_state != state) |=> state == nvts_pkg::NVTS_VERIFY)
        else $error("no verify after write");
    a_verify_reads: assert property (@(posedge clk) disable iff (!rst_n)
        state == nvts_pkg::NVTS_VERIFY |-> cell_read_en && !cell_write_en && !cell_erase)
        else $error("verify without read");
    a_read_active: assert property (@(posedge clk) disable iff (!rst_n)
        state == nvts_pkg::NVTS_READ |-> status.mtp_sequence_active)
        else $error("read without active");
    a_setup_clear: assert property (@(posedge clk) disable iff (!rst_n)
        state == nvts_pkg::NVTS_RD_SETUP
        |-> !status.mtp_sequence_active && !status.write_success)
        else $error("setup pair not 00");
    a_done_pair: assert property (@(posedge clk) disable iff (!rst_n)
        state == nvts_pkg::NVTS_RD_DONE
        |-> status.mtp_sequence_active && status.write_success)
        else $error("done pair not 11");
    a_ready_pair: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_RD_DONE && next_state == nvts_pkg::NVTS_IDLE)
        |=> !status.mtp_sequence_active && status.write_success)
        else $error("ready pair not 01");
    a_hw_starts: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_IDLE && hw_rise && !display_on)
        |=> state == nvts_pkg::NVTS_RD_SETUP)
        else $error("no read after hardware reset");
    a_soft_no_read: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_IDLE && !hw_rise && cmd_wr && !pend
        && wdata == `NVTS_CMD_SYS_RESET) |=> state == nvts_pkg::NVTS_IDLE)
        else $error("read after software reset");
    a_try_limit: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_VERIFY && next_state == nvts_pkg::NVTS_WRITE)
        |-> tries != `NVTS_MAX_TRIES)
        else $error("too many tries");
    a_retry_path: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_VERIFY && tmr_done && cell_in != cell_out
        && tries != `NVTS_MAX_TRIES)
        |=> state == nvts_pkg::NVTS_WRITE && status.mtp_sequence_active)
        else $error("no retry after failed verify");
    a_abort_flag: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_VERIFY && tmr_done && cell_in != cell_out
        && tries == `NVTS_MAX_TRIES) |=> state == nvts_pkg::NVTS_IDLE
        && !status.write_success && !status.mtp_sequence_active)
        else $error("no abort after third failure");
    a_prog_level: assert property (@(posedge clk) disable iff (!rst_n)
        (cell_write_en || cell_erase) |-> hv_level == levels.program_level_setting)
        else $error("wrong level");
    a_read_level: assert property (@(posedge clk) disable iff (!rst_n)
        cell_read_en |-> hv_level == levels.read_level_setting)
        else $error("wrong read level");
    a_ok_end: assert property (@(posedge clk) disable iff (!rst_n)
        (state == nvts_pkg::NVTS_VERIFY && tmr_done && cell_in == cell_out)
        |=> status.write_success && !status.mtp_sequence_active) else $error("no success");
    a_op_start: assert property (@(posedge clk) disable iff (!rst_n)
        start_op |=> state == nvts_pkg::NVTS_WRITE && status.mtp_sequence_active
        && !status.write_success)
        else $error("operation start wrong");
    a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd |=> rdata[0] == $past(status.mtp_sequence_active)) else $error("status mismatch");
    a_status_ok: assert property (@(posedge clk) disable iff (!rst_n)
        rd |=> rdata[2] == $past(status.write_success)) else $error("flag mismatch");
    a_status_variant: assert property (@(posedge clk) disable iff (!rst_n)
        rd |=> rdata[1] == MTP_VARIANT) else $error("variant mismatch");
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == 8'h00) else $error("read data without strobe");
    a_trim_sub: assert property (@(posedge clk) disable iff (!rst_n)
        (cells[5] && {1'b0, contrast_potentiometer} >= {4'h0, cells[4:0]})
        |=> contrast_trimmed == $past(contrast_potentiometer) - ($past(cells) & 8'h1f))
        else $error("trim not subtracted");
    a_trim_add: assert property (@(posedge clk) disable iff (!rst_n)
        (!cells[5] && {1'b0, contrast_potentiometer} + {4'h0, cells[4:0]} < 9'h100)
        |=> contrast_trimmed == $past(contrast_potentiometer) + ($past(cells) & 8'h1f))
        else $error("trim not added");
    c_auto_read: cover property (@(posedge clk) state == nvts_pkg::NVTS_RD_DONE);
    c_retry: cover property (@(posedge clk) state == nvts_pkg::NVTS_VERIFY ##1
        state == nvts_pkg::NVTS_WRITE);
    c_erase: cover property (@(posedge clk) start_op && wdata[2:0] == `NVTS_OP_ERASE);
    c_program: cover property (@(posedge clk) start_op && wdata[2:0] == `NVTS_OP_PROGRAM);
    c_abort: cover property (@(posedge clk) state == nvts_pkg::NVTS_VERIFY && tmr_done
        && tries == `NVTS_MAX_TRIES && cell_in != cell_out);
endmodule : nvts_sequencer
`default_nettype wire

/* nvts_cell_model.sv */
`timescale 1ns/100ps
`default_nettype none
module nvts_cell_model (
    // Clock and test control
    input wire logic clk,
    input wire logic load,
    input wire logic stuck,
    input wire logic [7:0] init,
    // Array side
    input wire logic [7:0] cell_out,
    input wire logic cell_read_en,
    input wire logic cell_write_en,
    input wire logic cell_erase,
    input wire logic [7:0] hv_level,
    output logic [7:0] cell_in,
    // Observation
    output logic [7:0] cells,
    output logic [7:0] hv_seen,
    output int wr_eps,
    output int wr_len
);
    logic act_q = 1'b0;
    wire act = cell_write_en | cell_erase;
    assign cell_in = cell_read_en ? cells : ~cells;
    always @(posedge clk) begin
        act_q <= act;
        if (load) begin
            cells <= init;
        end else if (act && !stuck) begin
            cells <= cell_out;
        end
        if (act) begin
            hv_seen <= hv_level;
            wr_len <= act_q ? wr_len + 1 : 1;
            wr_eps <= act_q ? wr_eps : wr_eps + 1;
        end
    end
endmodule : nvts_cell_model
`default_nettype wire

/* nvts_sequencer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "nvts_defines.svh"
module nvts_sequencer_bench;
    localparam int TICK = 2;
    // Variant value is arbitrary
    localparam logic VARIANT = 1'b0;
    logic clk = 1'b0, rst_n = 1'b0, hw = 1'b0, wr = 1'b0, rd = 1'b0, load = 1'b1;
    logic stuck = 1'b0, rd_q = 1'b0, cre, cwe, cer, disp;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pot = 8'h00, init, rdata, cell_in, cell_out;
    logic [7:0] hv_level, trimmed, trim, cells, hv_seen, last, acc;
    logic [1:0] prev;
    nvts_pkg::nvts_levels_t levels;
    int wr_eps, wr_len, fails = 0, checks = 0, cyc = 0, seed = 31, e0, i, n;
    logic [8:0] notes[$];
    logic [8:0] note;
    nvts_sequencer #(.MTP_VARIANT(VARIANT), .TICK_CYCLES(TICK)) DUT (.clk(clk), .rst_n(rst_n),
        .hw_reset_event(hw), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cell_in(cell_in), .cell_out(cell_out), .cell_read_en(cre), .cell_write_en(cwe),
        .cell_erase(cer), .levels(levels), .hv_level(hv_level), .contrast_potentiometer(pot),
        .contrast_trimmed(trimmed), .trim_offset(trim), .display_on(disp));
    nvts_cell_model cells_m (.clk(clk), .load(load), .stuck(stuck), .init(init),
        .cell_out(cell_out), .cell_read_en(cre), .cell_write_en(cwe), .cell_erase(cer),
        .hv_level(hv_level), .cell_in(cell_in), .cells(cells), .hv_seen(hv_seen),
        .wr_eps(wr_eps), .wr_len(wr_len));
    // ----------------------------------------
    // Clock, monitor and host tasks
    // ----------------------------------------
    always #2 clk = ~clk;
    always @(posedge clk) begin
        rd_q <= rd;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task cmp(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    // Status answer stands only in the cycle after the strobe
    always @(negedge clk) begin
        if (rd_q) begin
            last = rdata;
            note = notes.pop_front();
            cmp("variant", {15'h0, VARIANT}, {15'h0, rdata[1]});
            if (note[8]) cmp("status", {8'h00, note[7:0]}, {8'h00, rdata});
        end
    end
    task cmd(input logic [7:0] b);
        @(posedge clk);
        wdata <= b;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : cmd
    task cmd2(input logic [7:0] b, input logic [7:0] d);
        cmd(b);
        cmd(d);
    endtask : cmd2
    task stat(input logic c, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        notes.push_back({c, e});
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        #1;
    endtask : stat
    task wait_idle();
        for (int k = 0; k < 300; k++) begin
            stat(1'b0, 8'h00);
            if (last[0] === 1'b0) break;
        end
    endtask : wait_idle
    function automatic logic [7:0] st(input logic w, input logic m);
        return {5'h00, w, VARIANT, m};
    endfunction : st
    function automatic logic [7:0] sat(input logic [7:0] p, input logic [5:0] t);
        int v;
        v = t[5] ? int'(p) - int'(t[4:0]) : int'(p) + int'(t[4:0]);
        v = (v < 0) ? 0 : (v > 255) ? 255 : v;
        return 8'(v);
    endfunction : sat
    task tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        init = 8'($random(seed)) | 8'h20;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        load <= 1'b0;
        stat(1'b1, st(1'b0, 1'b0));
        cmp("levels", 16'h0039, levels);
        cmp("hv_level", 16'h0000, {8'h00, hv_level});
        @(posedge clk);
        hw <= 1'b1;
        repeat (4) @(posedge clk);
        hw <= 1'b0;
        acc = 8'h00;
        n = 0;
        prev = 2'b11;
        for (i = 0; i < 300 && prev !== 2'b01; i++) begin
            stat(1'b0, 8'h00);
            if ({last[0], last[2]} !== prev) n++;
            if ({last[0], last[2]} !== prev) acc = {acc[5:0], last[0], last[2]};
            prev = {last[0], last[2]};
        end
        cmp("auto_seq", 16'h042d, {8'(n), acc});
        cmp("trim_offset", {10'h0, init[5:0]}, {8'h00, trim});
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            pot <= (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            repeat (4) @(posedge clk);
            cmp("contrast", {8'h00, sat(pot, init[5:0])}, {8'h00, trimmed});
        end
        $display("test auto read done");
        cmd2(`NVTS_CMD_READ_LEVEL, 8'h12);
        cmd2(`NVTS_CMD_PROG_LEVEL, 8'h45);
        @(negedge clk);
        cmp("levels", 16'h1245, levels);
        cmp("hv_level", 16'h0012, {8'h00, hv_level});
        cmd2(`NVTS_CMD_READ_LEVEL, 8'h00);
        cmd2(`NVTS_CMD_PROG_LEVEL, 8'h39);
        cmd2(`NVTS_CMD_WR_TIMER, 8'h03);
        cmd2(`NVTS_CMD_RD_TIMER, 8'h01);
        cmd2(`NVTS_CMD_MASK, 8'hff);
        cmd2(`NVTS_CMD_CONTROL, 8'h0a);
        wait_idle();
        stat(1'b1, st(1'b1, 1'b0));
        cmp("cells", 16'h0000, {8'h00, cells});
        cmp("hv_seen", 16'h0039, {8'h00, hv_seen});
        cmp("wr_len", 16'(3 * TICK), 16'(wr_len));
        cmd2(`NVTS_CMD_MASK, 8'h01);
        cmd2(`NVTS_CMD_CONTROL, 8'h0b);
        wait_idle();
        stat(1'b1, st(1'b1, 1'b0));
        cmp("cells", 16'h0001, {8'h00, cells});
        $display("test erase program done");
        e0 = wr_eps;
        @(posedge clk);
        stuck <= 1'b1;
        cmd2(`NVTS_CMD_MASK, 8'h02);
        cmd2(`NVTS_CMD_CONTROL, 8'h0b);
        wait_idle();
        stat(1'b1, st(1'b0, 1'b0));
        cmp("attempts", 16'h0003, 16'(wr_eps - e0));
        stuck <= 1'b0;
        $display("test retry done");
        cmd2(`NVTS_CMD_MASK, 8'hff);
        cmd2(`NVTS_CMD_CONTROL, 8'h0a);
        cmd({`NVTS_CMD_DISP_EN_HI, 1'b1});
        wait_idle();
        cmp("display_on", 16'h0000, {15'h0, disp});
        cmd({`NVTS_CMD_DISP_EN_HI, 1'b1});
        repeat (2) @(posedge clk);
        cmp("display_on", 16'h0001, {15'h0, disp});
        cmd2(`NVTS_CMD_MASK, 8'h01);
        cmd2(`NVTS_CMD_CONTROL, 8'h0b);
        stat(1'b1, st(1'b1, 1'b0));
        cmp("cells", 16'h0000, {8'h00, cells});
        cmd(`NVTS_CMD_SYS_RESET);
        repeat (2) @(posedge clk);
        cmp("display_on", 16'h0000, {15'h0, disp});
        for (i = 0; i < 3; i++) stat(1'b1, st(1'b1, 1'b0));
        $display("test exclusion done");
        tally_and_finish();
    end
endmodule : nvts_sequencer_bench
`default_nettype wire
